// ==== logic/iopd_pkg.sv ====
// Purpose: Constants for the I/O port and automatic power-down block
// Assumes: Single 100 MHz clock, asynchronous active-low reset
// Notes:   Ports A-C are eight bits wide, port D uses bits 2 and 1
package iopd_pkg;
  localparam int          PORT_W      = 8;
  localparam int          MC_W        = 8;
  localparam logic [3:0]  PD_LIMIT    = 4'hF;
  localparam logic [7:0]  RST_DIR     = 8'h00;
  localparam logic [7:0]  RST_CTL     = 8'h00;
  localparam logic [7:0]  RST_DOUT    = 8'h00;
  localparam logic [7:0]  RST_DRV     = 8'h00;
  localparam logic [7:0]  RST_MC      = 8'h00;
  localparam logic [7:0]  PD_USED_MSK = 8'h06;
  localparam int          PD_BIT_SEL  = 2;
  localparam int          PD_BIT_CLK  = 1;
  localparam logic [7:0]  PC_BC_MSK   = 8'h9C;
  // Register select codes on the CPU register port
  localparam logic [3:0]  SEL_DIN_A   = 4'h0;
  localparam logic [3:0]  SEL_DIN_B   = 4'h1;
  localparam logic [3:0]  SEL_DIN_C   = 4'h2;
  localparam logic [3:0]  SEL_DIN_D   = 4'h3;
  localparam logic [3:0]  SEL_DOUT_A  = 4'h4;
  localparam logic [3:0]  SEL_DOUT_B  = 4'h5;
  localparam logic [3:0]  SEL_DOUT_C  = 4'h6;
  localparam logic [3:0]  SEL_DOUT_D  = 4'h7;
  localparam logic [3:0]  SEL_DIR_A   = 4'h8;
  localparam logic [3:0]  SEL_DIR_B   = 4'h9;
  localparam logic [3:0]  SEL_DIR_C   = 4'hA;
  localparam logic [3:0]  SEL_DIR_D   = 4'hB;
  localparam logic [3:0]  SEL_CTL_A   = 4'hC;
  localparam logic [3:0]  SEL_CTL_B   = 4'hD;
  localparam logic [3:0]  SEL_MC_AB   = 4'hE;
  localparam logic [3:0]  SEL_MC_BC   = 4'hF;
endpackage

// ==== logic/iopd_top.sv ====
// Purpose: Ports A-D pin control, CPU register access and auto power-down
// Assumes: Pin, strobe and logic clock inputs are asynchronous
// Notes:   Drive-select registers are reached by a separate select line
`timescale 1ns/1ns
module iopd_top (
  // Clock and reset
  input  wire logic                       I_CLK_SYS,
  input  wire logic                       I_RSTN,
  // CPU register port
  input  wire logic                       I_REG_WR,
  input  wire logic                       I_REG_DRV,
  input  wire logic [3:0]                 I_REG_SEL,
  input  wire logic [1:0]                 I_REG_DRV_PORT,
  input  wire logic [7:0]                 I_REG_WDATA,
  output logic      [7:0]                 O_REG_RDATA,
  // CPU address and strobe
  input  wire logic [7:0]                 I_CPU_ADDR,
  input  wire logic                       I_ADDR_STROBE,
  // Mode and power configuration
  input  wire logic                       I_PERIPHERAL_IO_BIT,
  input  wire logic                       I_PERIPHERAL_SELECT,
  input  wire logic                       I_APD_ENABLE,
  input  wire logic                       I_BLOCK_CPU_CTRL,
  input  wire logic                       I_BLOCK_LOGIC_CLK,
  input  wire logic                       I_CPU_RD,
  input  wire logic                       I_CPU_WR,
  // Logic array terms
  input  wire logic [7:0]                 I_OE_TERM_A,
  input  wire logic [7:0]                 I_OE_TERM_B,
  input  wire logic [7:0]                 I_OE_TERM_C,
  input  wire logic [7:0]                 I_OE_TERM_D,
  input  wire logic [7:0]                 I_MC_AB_LOGIC,
  input  wire logic [7:0]                 I_MC_BC_LOGIC,
  input  wire logic [7:0]                 I_MC_AB_ON_A,
  input  wire logic [7:0]                 I_MC_BC_ON_B,
  input  wire logic [1:0]                 I_EXT_CS,
  input  wire logic [1:0]                 I_EXT_CS_EN,
  // Pins
  input  wire logic [7:0]                 I_PA,
  input  wire logic [7:0]                 I_PB,
  input  wire logic [7:0]                 I_PC,
  input  wire logic [7:0]                 I_PD,
  output logic      [7:0]                 O_PA,
  output logic      [7:0]                 O_PB,
  output logic      [7:0]                 O_PC,
  output logic      [7:0]                 O_PD,
  output logic      [7:0]                 O_PA_OE,
  output logic      [7:0]                 O_PB_OE,
  output logic      [7:0]                 O_PC_OE,
  output logic      [7:0]                 O_PD_OE,
  // Power and gating status
  output logic                            O_POWER_DOWN_FLAG,
  output logic                            O_MEM_SELECT_EN,
  output logic                            O_CPU_BUS_EN,
  output logic                            O_ARRAY_CPU_CTRL_EN,
  output logic                            O_ARRAY_LOGIC_CLK
);
  import iopd_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisers: three stages, a change counts when stages 2 and 3 agree
  logic [35:0] s1_q, s2_q, s3_q, s1_d, s2_d, s3_d;
  logic [35:0] raw;
  logic [35:0] stab_q, stab_d;
  assign raw = {I_PD, I_PC, I_PB, I_PA, I_PD[PD_BIT_CLK], I_ADDR_STROBE, I_PD[PD_BIT_SEL], 1'b0};

  always_comb begin
    s1_d   = raw;
    s2_d   = s1_q;
    s3_d   = s2_q;
    stab_d = stab_q;
    for (int i = 0; i < 36; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        stab_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      s1_q   <= '0;
      s2_q   <= '0;
      s3_q   <= '0;
      stab_q <= '0;
    end else begin
      s1_q   <= s1_d;
      s2_q   <= s2_d;
      s3_q   <= s3_d;
      stab_q <= stab_d;
    end
  end

  logic [7:0] pin_a, pin_b, pin_c, pin_d;
  logic       lclk_s, strobe_s, msel_s;
  assign pin_a    = stab_q[11:4];
  assign pin_b    = stab_q[19:12];
  assign pin_c    = stab_q[27:20];
  assign pin_d    = stab_q[35:28] & PD_USED_MSK;
  assign lclk_s   = stab_q[3];
  assign strobe_s = stab_q[2];
  assign msel_s   = stab_q[1];

  //////////////////////////////////////////////////////////////////////////////
  // Port configuration and data registers
  logic [7:0] dir_q [4];
  logic [7:0] dir_d [4];
  logic [7:0] drv_q [4];
  logic [7:0] drv_d [4];
  logic [7:0] dout_q [4];
  logic [7:0] dout_d [4];
  logic [7:0] ctl_q [2];
  logic [7:0] ctl_d [2];
  logic [7:0] mcab_q, mcab_d, mcbc_q, mcbc_d;
  logic       pdn_q;
  logic       reg_ok;

  // Bus isolated from the arrays while powered down
  assign reg_ok = I_REG_WR && !pdn_q;

  always_comb begin
    dir_d  = dir_q;
    drv_d  = drv_q;
    dout_d = dout_q;
    ctl_d  = ctl_q;
    mcab_d = I_MC_AB_LOGIC;
    mcbc_d = I_MC_BC_LOGIC;
    if (reg_ok && I_REG_DRV) begin
      drv_d[I_REG_DRV_PORT] = (I_REG_DRV_PORT == 2'h3) ? (I_REG_WDATA & PD_USED_MSK) : I_REG_WDATA;
    end else if (reg_ok) begin
      unique case (I_REG_SEL)
        SEL_DOUT_A: dout_d[0] = I_REG_WDATA;
        SEL_DOUT_B: dout_d[1] = I_REG_WDATA;
        SEL_DOUT_C: dout_d[2] = I_REG_WDATA;
        SEL_DOUT_D: dout_d[3] = I_REG_WDATA & PD_USED_MSK;
        SEL_DIR_A:  dir_d[0]  = I_REG_WDATA;
        SEL_DIR_B:  dir_d[1]  = I_REG_WDATA;
        SEL_DIR_C:  dir_d[2]  = I_REG_WDATA;
        SEL_DIR_D:  dir_d[3]  = I_REG_WDATA & PD_USED_MSK;
        SEL_CTL_A:  ctl_d[0]  = I_REG_WDATA;
        SEL_CTL_B:  ctl_d[1]  = I_REG_WDATA;
        SEL_MC_AB:  mcab_d    = I_REG_WDATA;
        SEL_MC_BC:  mcbc_d    = I_REG_WDATA;
        default:    ;
      endcase
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      for (int p = 0; p < 4; p++) begin
        dir_q[p]  <= RST_DIR;
        drv_q[p]  <= RST_DRV;
        dout_q[p] <= RST_DOUT;
      end
      ctl_q[0] <= RST_CTL;
      ctl_q[1] <= RST_CTL;
      mcab_q   <= RST_MC;
      mcbc_q   <= RST_MC;
    end else begin
      dir_q  <= dir_d;
      drv_q  <= drv_d;
      dout_q <= dout_d;
      ctl_q  <= ctl_d;
      mcab_q <= mcab_d;
      mcbc_q <= mcbc_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register read-back
  logic [7:0] rdata_d, rdata_q;
  always_comb begin
    rdata_d = 8'h00;
    if (I_REG_DRV) begin
      rdata_d = drv_q[I_REG_DRV_PORT];
    end else begin
      unique case (I_REG_SEL)
        SEL_DIN_A:  rdata_d = pin_a;
        SEL_DIN_B:  rdata_d = pin_b;
        SEL_DIN_C:  rdata_d = pin_c;
        SEL_DIN_D:  rdata_d = pin_d;
        SEL_DOUT_A: rdata_d = dout_q[0];
        SEL_DOUT_B: rdata_d = dout_q[1];
        SEL_DOUT_C: rdata_d = dout_q[2];
        SEL_DOUT_D: rdata_d = dout_q[3];
        SEL_DIR_A:  rdata_d = dir_q[0];
        SEL_DIR_B:  rdata_d = dir_q[1];
        SEL_DIR_C:  rdata_d = dir_q[2];
        SEL_DIR_D:  rdata_d = dir_q[3];
        SEL_CTL_A:  rdata_d = ctl_q[0];
        SEL_CTL_B:  rdata_d = ctl_q[1];
        SEL_MC_AB:  rdata_d = mcab_q;
        SEL_MC_BC:  rdata_d = mcbc_q;
        default:    rdata_d = 8'h00;
      endcase
    end
    if (pdn_q) begin
      rdata_d = 8'h00;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end
  assign O_REG_RDATA = rdata_q;

  //////////////////////////////////////////////////////////////////////////////
  // Automatic power-down: idle periods of the logic clock input
  logic [3:0] idle_q, idle_d;
  logic       lclk_prev_q, strobe_prev_q, pdn_d;
  logic       lclk_rise, strobe_rise;
  assign lclk_rise   = lclk_s && !lclk_prev_q;
  assign strobe_rise = strobe_s && !strobe_prev_q;

  always_comb begin
    idle_d = idle_q;
    pdn_d  = pdn_q;
    if (!I_APD_ENABLE || strobe_rise) begin
      idle_d = 4'h0;
    end else if (lclk_rise && idle_q != PD_LIMIT) begin
      idle_d = idle_q + 4'h1;
    end
    // Enable alone arms power-down; no separate enable bit
    if (I_APD_ENABLE && idle_d == PD_LIMIT) begin
      pdn_d = 1'b1;
    end
    if (strobe_rise || !msel_s || !I_APD_ENABLE) begin
      pdn_d = 1'b0;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      idle_q        <= 4'h0;
      pdn_q         <= 1'b0;
      lclk_prev_q   <= 1'b0;
      strobe_prev_q <= 1'b0;
    end else begin
      idle_q        <= idle_d;
      pdn_q         <= pdn_d;
      lclk_prev_q   <= lclk_s;
      strobe_prev_q <= strobe_s;
    end
  end

  assign O_POWER_DOWN_FLAG   = pdn_q;
  assign O_MEM_SELECT_EN     = !msel_s && !pdn_q;
  assign O_CPU_BUS_EN        = !pdn_q;
  assign O_ARRAY_CPU_CTRL_EN = !I_BLOCK_CPU_CTRL && (I_CPU_RD || I_CPU_WR);
  assign O_ARRAY_LOGIC_CLK   = lclk_s && !I_BLOCK_LOGIC_CLK;

  //////////////////////////////////////////////////////////////////////////////
  // Pin drive
  logic [7:0] addr_q, addr_d;
  logic       periph;
  assign addr_d = I_ADDR_STROBE ? I_CPU_ADDR : addr_q;
  assign periph = I_PERIPHERAL_IO_BIT && I_PERIPHERAL_SELECT;

  always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      addr_q <= 8'h00;
    end else begin
      addr_q <= addr_d;
    end
  end

  logic [7:0] a_d, b_d, c_d, d_d, aoe_d, boe_d, coe_d, doe_d;
  logic [7:0] a_q, b_q, c_q, d_q;
  logic [7:0] amode_a, amode_b;

  always_comb begin
    // Address mode needs control and direction both set
    amode_a = ctl_q[0] & dir_q[0];
    amode_b = ctl_q[1] & dir_q[1];
    aoe_d   = dir_q[0] | I_OE_TERM_A;
    boe_d   = dir_q[1] | I_OE_TERM_B;
    coe_d   = dir_q[2] | I_OE_TERM_C;
    doe_d   = (dir_q[3] | I_OE_TERM_D | {5'h00, I_EXT_CS_EN, 1'b0}) & PD_USED_MSK;
    for (int i = 0; i < 8; i++) begin
      a_d[i] = amode_a[i] ? addr_q[i] :
               (I_MC_AB_ON_A[i] ? mcab_q[i] : dout_q[0][i]);
      b_d[i] = amode_b[i] ? addr_q[i] :
               (!I_MC_AB_ON_A[i] ? mcab_q[i] :
               (I_MC_BC_ON_B[i] ? mcbc_q[i] : dout_q[1][i]));
      c_d[i] = (!I_MC_BC_ON_B[i] && PC_BC_MSK[i]) ? mcbc_q[i] : dout_q[2][i];
    end
    // Chip selects come from the array directly, not from macrocells
    d_d = (dout_q[3] & ~{5'h00, I_EXT_CS_EN, 1'b0}) |
          ({5'h00, I_EXT_CS & I_EXT_CS_EN, 1'b0});
    d_d = d_d & PD_USED_MSK;
    if (periph) begin
      aoe_d = I_OE_TERM_A;
    end
    if (pdn_q) begin
      // CPU and logic pins hold level; address pins undefined, held here
      a_d = a_q;
      b_d = b_q;
      c_d = c_q;
      d_d = d_q;
      if (periph) begin
        aoe_d = 8'h00;
      end
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      a_q <= 8'h00;
      b_q <= 8'h00;
      c_q <= 8'h00;
      d_q <= 8'h00;
    end else begin
      a_q <= a_d;
      b_q <= b_d;
      c_q <= c_d;
      d_q <= d_d;
    end
  end

  assign O_PA    = a_q;
  assign O_PB    = b_q;
  assign O_PC    = c_q;
  assign O_PD    = d_q;
  assign O_PA_OE = aoe_d;
  assign O_PB_OE = boe_d;
  assign O_PC_OE = coe_d;
  assign O_PD_OE = doe_d;
endmodule

// ==== dv/iopd_top_asserts.sv ====
// Purpose: Port-level checks on iopd_top
// Assumes: One clock, async active-low reset
// Notes:   Pin inputs pass a sync chain, so waits allow a few cycles
`timescale 1ns/1ns
module iopd_top_asserts (
  // Clock and reset
  input  wire logic       I_CLK_SYS,
  input  wire logic       I_RSTN,
  // Watched inputs
  input  wire logic       I_ADDR_STROBE,
  input  wire logic       I_PERIPHERAL_IO_BIT,
  input  wire logic       I_PERIPHERAL_SELECT,
  input  wire logic       I_APD_ENABLE,
  input  wire logic       I_BLOCK_CPU_CTRL,
  input  wire logic       I_BLOCK_LOGIC_CLK,
  input  wire logic [7:0] I_OE_TERM_A,
  input  wire logic [7:0] I_PD,
  // Watched outputs
  input  wire logic [7:0] O_REG_RDATA,
  input  wire logic [7:0] O_PC,
  input  wire logic [7:0] O_PA_OE,
  input  wire logic       O_POWER_DOWN_FLAG,
  input  wire logic       O_MEM_SELECT_EN,
  input  wire logic       O_CPU_BUS_EN,
  input  wire logic       O_ARRAY_CPU_CTRL_EN,
  input  wire logic       O_ARRAY_LOGIC_CLK
);
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RSTN);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_wake_req; O_POWER_DOWN_FLAG && $rose(I_ADDR_STROBE); endsequence
  sequence s_left; ##[1:8] !O_POWER_DOWN_FLAG; endsequence
  property p_wake_strobe; s_wake_req |-> s_left; endproperty
  a_wake_strobe: assert property (p_wake_strobe) else $error("no wake on strobe");
  property p_wake_sel; (!I_PD[2]) [*6] |=> !O_POWER_DOWN_FLAG; endproperty
  a_wake_sel: assert property (p_wake_sel) else $error("no wake on select low");
  property p_en_off; !I_APD_ENABLE |-> ##2 !O_POWER_DOWN_FLAG; endproperty
  a_en_off: assert property (p_en_off) else $error("flag without enable");
  property p_iso; O_POWER_DOWN_FLAG |-> !O_CPU_BUS_EN && !O_MEM_SELECT_EN; endproperty
  a_iso: assert property (p_iso) else $error("bus not isolated");
  property p_rd_zero; O_POWER_DOWN_FLAG && $past(O_POWER_DOWN_FLAG) |-> O_REG_RDATA == 8'h00; endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("read data in power-down");
  property p_hold; O_POWER_DOWN_FLAG && $past(O_POWER_DOWN_FLAG) |-> $stable(O_PC); endproperty
  a_hold: assert property (p_hold) else $error("pins moved in power-down");
  property p_per_oe;
    I_PERIPHERAL_IO_BIT && I_PERIPHERAL_SELECT |-> O_PA_OE == (O_POWER_DOWN_FLAG ? 8'h00 : I_OE_TERM_A);
  endproperty
  a_per_oe: assert property (p_per_oe) else $error("peripheral enable wrong");
  property p_blk_clk; I_BLOCK_LOGIC_CLK |-> !O_ARRAY_LOGIC_CLK; endproperty
  a_blk_clk: assert property (p_blk_clk) else $error("logic clock not blocked");
  property p_blk_ctl; I_BLOCK_CPU_CTRL |-> !O_ARRAY_CPU_CTRL_EN; endproperty
  a_blk_ctl: assert property (p_blk_ctl) else $error("cpu controls not blocked");
  property p_cs_in; I_PD[2] [*6] |-> !O_MEM_SELECT_EN; endproperty
  a_cs_in: assert property (p_cs_in) else $error("selects not disabled");
endmodule
bind iopd_top iopd_top_asserts iopd_top_asserts_i (
  .I_CLK_SYS(I_CLK_SYS), .I_RSTN(I_RSTN), .I_ADDR_STROBE(I_ADDR_STROBE),
  .I_PERIPHERAL_IO_BIT(I_PERIPHERAL_IO_BIT), .I_PERIPHERAL_SELECT(I_PERIPHERAL_SELECT),
  .I_APD_ENABLE(I_APD_ENABLE),
  .I_BLOCK_CPU_CTRL(I_BLOCK_CPU_CTRL), .I_BLOCK_LOGIC_CLK(I_BLOCK_LOGIC_CLK),
  .I_OE_TERM_A(I_OE_TERM_A), .I_PD(I_PD), .O_REG_RDATA(O_REG_RDATA), .O_PC(O_PC),
  .O_PA_OE(O_PA_OE), .O_POWER_DOWN_FLAG(O_POWER_DOWN_FLAG), .O_MEM_SELECT_EN(O_MEM_SELECT_EN),
  .O_CPU_BUS_EN(O_CPU_BUS_EN), .O_ARRAY_CPU_CTRL_EN(O_ARRAY_CPU_CTRL_EN),
  .O_ARRAY_LOGIC_CLK(O_ARRAY_LOGIC_CLK));

// ==== dv/iopd_cpu.sv ====
// Purpose: CPU side of the register port and address strobe
// Assumes: Requests change just after a rising edge
// Notes:   Released buses show the inverse of the last value
`timescale 1ns/1ns
module iopd_cpu (
  // Clock
  input  wire logic       i_clk,
  // Register port
  output logic            o_wr,
  output logic            o_drv,
  output logic [3:0]      o_sel,
  output logic [1:0]      o_port,
  output logic [7:0]      o_wdata,
  input  wire logic [7:0] i_rdata,
  // Address and strobe
  output logic [7:0]      o_addr,
  output logic            o_strobe
);
  initial begin
    o_wr = 1'b0;
    o_drv = 1'b0;
    o_sel = 4'h0;
    o_port = 2'h0;
    o_wdata = 8'h00;
    o_addr = 8'h00;
    o_strobe = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic d, input logic [3:0] s, input logic [1:0] p, input logic [7:0] v);
    @(posedge i_clk);
    o_wr <= 1'b1;
    o_drv <= d;
    o_sel <= s;
    o_port <= p;
    o_wdata <= v;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_wdata <= ~v;
  endtask
  // Data read at the edge, before that edge's update lands
  task automatic rd(input logic d, input logic [3:0] s, input logic [1:0] p, output logic [7:0] v);
    @(posedge i_clk);
    o_drv <= d;
    o_sel <= s;
    o_port <= p;
    repeat (2) @(posedge i_clk);
    v = i_rdata;
  endtask
  // Long strobe so the sync chain cannot miss it
  task automatic pulse(input logic [7:0] a);
    @(posedge i_clk);
    o_addr <= a;
    o_strobe <= 1'b1;
    repeat (3) @(posedge i_clk);
    o_strobe <= 1'b0;
    @(posedge i_clk);
    o_addr <= ~a;
  endtask
endmodule

// ==== dv/tb.sv ====
// Purpose: Self-checking bench for iopd_top
// Assumes: 100 MHz clock, fixed random seed
// Notes:   Port C bits 2,3,4,7 and port D chip selects are masked where shared
`timescale 1ns/1ns
module tb;
  import iopd_pkg::*;
  logic             clk, rstn, wr, drv, stb, peripheral_io_bit, psel, auto_power_down_unit, bcc, blc, crd, cwr;
  logic [3:0]       sel;
  logic [1:0]       dport, ecs, ecse;
  logic [7:0]       wd, addr, mab, mbc, maba, mbcb, v, w, rdat;
  logic [3:0][7:0]  oe, pin;
  wire  [3:0][7:0]  po, poe;
  wire  [7:0]       rdw;
  wire              flag, mse, cbe, ace, alc;
  int               seed, bad_count, cmp_count, p, i;
  iopd_top iopd_top_i (
    .I_CLK_SYS(clk), .I_RSTN(rstn), .I_REG_WR(wr), .I_REG_DRV(drv), .I_REG_SEL(sel),
    .I_REG_DRV_PORT(dport), .I_REG_WDATA(wd), .O_REG_RDATA(rdw), .I_CPU_ADDR(addr), .I_ADDR_STROBE(stb),
    .I_PERIPHERAL_IO_BIT(peripheral_io_bit), .I_PERIPHERAL_SELECT(psel), .I_APD_ENABLE(auto_power_down_unit), .I_BLOCK_CPU_CTRL(bcc),
    .I_BLOCK_LOGIC_CLK(blc), .I_CPU_RD(crd), .I_CPU_WR(cwr), .I_OE_TERM_A(oe[0]), .I_OE_TERM_B(oe[1]),
    .I_OE_TERM_C(oe[2]), .I_OE_TERM_D(oe[3]), .I_MC_AB_LOGIC(mab), .I_MC_BC_LOGIC(mbc),
    .I_MC_AB_ON_A(maba), .I_MC_BC_ON_B(mbcb), .I_EXT_CS(ecs), .I_EXT_CS_EN(ecse),
    .I_PA(pin[0]), .I_PB(pin[1]), .I_PC(pin[2]), .I_PD(pin[3]), .O_PA(po[0]), .O_PB(po[1]), .O_PC(po[2]),
    .O_PD(po[3]), .O_PA_OE(poe[0]), .O_PB_OE(poe[1]), .O_PC_OE(poe[2]), .O_PD_OE(poe[3]),
    .O_POWER_DOWN_FLAG(flag), .O_MEM_SELECT_EN(mse), .O_CPU_BUS_EN(cbe), .O_ARRAY_CPU_CTRL_EN(ace),
    .O_ARRAY_LOGIC_CLK(alc));
  iopd_cpu iopd_cpu_i (
    .i_clk(clk), .o_wr(wr), .o_drv(drv), .o_sel(sel), .o_port(dport), .o_wdata(wd), .i_rdata(rdw),
    .o_addr(addr), .o_strobe(stb));
  always #5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] msk(input int q);
    return (q == 3) ? PD_USED_MSK : 8'hFF;
  endfunction
  function automatic logic [7:0] oe_exp(input logic [7:0] d, t);
    return d | t;
  endfunction
  task automatic chk(input logic [7:0] g, e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // n logic clock periods, module select held high
  task automatic pd1(input int n);
    repeat (n) begin
      @(posedge clk) pin[3] <= 8'h06;
      {crd, cwr} <= 2'($random(seed));
      repeat (6) @(posedge clk);
      pin[3] <= 8'h04;
      repeat (5) @(posedge clk);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    tally_and_finish();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h6beb;
    {bad_count, cmp_count} = 0;
    {clk, rstn, peripheral_io_bit, psel, auto_power_down_unit, bcc, blc, crd, cwr, ecs, ecse, mab, mbc, maba, mbcb} = 0;
    oe = $random(seed);
    pin = 0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    for (p = 0; p < 4; p++) begin
      iopd_cpu_i.rd(0, SEL_DIR_A + 4'(p), 0, rdat);
      chk(rdat, RST_DIR);
      iopd_cpu_i.rd(0, SEL_DOUT_A + 4'(p), 0, rdat);
      chk(rdat, RST_DOUT);
    end
    iopd_cpu_i.rd(0, SEL_CTL_B, 0, rdat);
    chk(rdat, RST_CTL);
    chk(poe[0], oe[0]);
    $display("test reset done");
    for (i = 0; i < 12; i++) begin
      p = i % 4;
      v = (i < 4) ? 8'hFF : 8'($random(seed));
      w = 8'($random(seed));
      iopd_cpu_i.wr(0, SEL_DIR_A + 4'(p), 0, v);
      iopd_cpu_i.wr(0, SEL_DOUT_A + 4'(p), 0, w);
      iopd_cpu_i.wr(1, 0, 2'(p), ~v);
      iopd_cpu_i.rd(0, SEL_DIR_A + 4'(p), 0, rdat);
      chk(rdat, v & msk(p));
      iopd_cpu_i.rd(0, SEL_DOUT_A + 4'(p), 0, rdat);
      chk(rdat, w & msk(p));
      iopd_cpu_i.rd(1, 0, 2'(p), rdat);
      chk(rdat, ~v & msk(p));
      if (p < 3) chk(poe[p], oe_exp(v, oe[p]));
      if (p == 2) chk(po[2] & poe[2] & 8'h63, w & oe_exp(v, oe[2]) & 8'h63);
      if (p == 3) chk(po[3] & poe[3] & PD_USED_MSK, w & oe_exp(v, oe[3]) & PD_USED_MSK);
      if (p < 2) begin
        iopd_cpu_i.wr(0, SEL_CTL_A + 4'(p), 0, w);
        iopd_cpu_i.rd(0, SEL_CTL_A + 4'(p), 0, rdat);
        chk(rdat, w);
        iopd_cpu_i.wr(0, SEL_CTL_A + 4'(p), 0, 8'h00);
      end
    end
    $display("test config done");
    for (p = 0; p < 3; p++) begin
      iopd_cpu_i.wr(0, SEL_DIR_A + 4'(p), 0, 8'h00);
      w = 8'($random(seed));
      pin[p] <= w;
      repeat (8) @(posedge clk);
      iopd_cpu_i.rd(0, SEL_DIN_A + 4'(p), 0, rdat);
      chk(rdat, w);
    end
    $display("test input done");
    // Macrocells moved off the port under test
    for (p = 0; p < 2; p++) begin
      maba <= (p == 1) ? 8'hFF : 8'h00;
      iopd_cpu_i.wr(0, SEL_CTL_A + 4'(p), 0, 8'hFF);
      iopd_cpu_i.wr(0, SEL_DIR_A + 4'(p), 0, 8'hFF);
      w = 8'($random(seed));
      iopd_cpu_i.pulse(w);
      repeat (4) @(posedge clk);
      chk(po[p], w);
      iopd_cpu_i.wr(0, SEL_CTL_A + 4'(p), 0, 8'h00);
    end
    $display("test address done");
    peripheral_io_bit <= 1'b1;
    psel <= 1'b1;
    mbcb <= 8'hFF;
    ecse <= 2'b11;
    ecs <= 2'($random(seed));
    mab <= 8'($random(seed));
    mbc <= 8'($random(seed));
    repeat (3) @(posedge clk);
    chk(poe[0], oe[0]);
    chk(po[3] & PD_USED_MSK, {5'h00, ecs, 1'b0});
    chk(po[0], mab);
    chk(po[1], mbc);
    iopd_cpu_i.rd(0, SEL_MC_AB, 0, rdat);
    chk(rdat, mab);
    iopd_cpu_i.rd(0, SEL_MC_BC, 0, rdat);
    chk(rdat, mbc);
    // Peripheral mode kept on so power-down must float port A
    ecse <= 2'b00;
    mbcb <= 8'h00;
    $display("test mode done");
    iopd_cpu_i.wr(0, SEL_DIR_C, 0, 8'hFF);
    w = 8'($random(seed));
    iopd_cpu_i.wr(0, SEL_DOUT_C, 0, w);
    {pin[3], blc, bcc} <= {8'h04, 2'b11};
    repeat (8) @(posedge clk);
    auto_power_down_unit <= 1'b1;
    pd1(14);
    chk(flag, 0);
    pd1(1);
    chk(flag, 1);
    iopd_cpu_i.wr(0, SEL_DOUT_C, 0, ~w);
    iopd_cpu_i.rd(0, SEL_DOUT_C, 0, rdat);
    chk(rdat, 8'h00);
    chk(po[2], (w & ~PC_BC_MSK) | (mbc & PC_BC_MSK));
    chk(poe[0], 8'h00);
    chk(cbe, 0);
    iopd_cpu_i.pulse(8'h00);
    repeat (8) @(posedge clk);
    chk(flag, 0);
    iopd_cpu_i.rd(0, SEL_DOUT_C, 0, rdat);
    chk(rdat, w);
    pd1(10);
    iopd_cpu_i.pulse(8'h00);
    pd1(10);
    chk(flag, 0);
    pd1(5);
    chk(flag, 1);
    pin[3] <= 8'h00;
    repeat (8) @(posedge clk);
    chk(flag, 0);
    pin[3] <= 8'h04;
    iopd_cpu_i.pulse(8'h00);
    pd1(15);
    chk(flag, 1);
    auto_power_down_unit <= 1'b0;
    repeat (2) @(posedge clk);
    chk(flag, 0);
    $display("test powerdown done");
    tally_and_finish();
  end
endmodule
